// File: rtcpt_counter.sv
`timescale 1ns/1ps
`include "rtcpt_regs.svh"
// Summary of operation
// - two-bit field picks counting clock source
// - counter is low and high byte, resets zero
// - counter write applies after two counting cycles
// - period bytes read/write, reset all ones
// - period write two cycles, busy meanwhile
// - compare bytes read/write, reset zero
// - interval code selects 4..32768 cycles, 0 off
// - tick control bit 0 enables tick timer
// - tick status shows control sync pending
// - tick request only while irq enable set
// - tick flag set per tick, write one clears
// - debug halt freezes tick unless run bit
// - counter wraps at period, sets wrap flag
// - match flag set when counter equals compare
// - 16-bit access through shared staging byte
module rtcpt_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counting clock sources
  input  wire logic        internal_fast_osc,
  input  wire logic        internal_slow_osc,
  input  wire logic        crystal_osc,
  input  wire logic        external_clock_pin,
  // debug
  input  wire logic        debug_halt,
  // interrupts
  output logic             irq,
  output logic             tick_irq
);

  rtcpt_pkg::rtcpt_state_t s_r;
  rtcpt_pkg::rtcpt_state_t s_nxt;
  rtcpt_tick_if            tif ();
  logic                    sel_w;
  logic                    tick_w;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] merge16(input logic [7:0] hi,
                                          input logic [7:0] lo);
    merge16 = {hi, lo};
  endfunction : merge16

  function automatic logic reg_hit(input logic [7:0] idx, input logic wr);
    case (idx)
      `RTCPT_IDX_STATUS, `RTCPT_IDX_INTFLAGS, `RTCPT_IDX_TEMP,
      `RTCPT_IDX_CLOCK_SOURCE_SEL, `RTCPT_IDX_CNT_L, `RTCPT_IDX_CNT_H,
      `RTCPT_IDX_PER_L, `RTCPT_IDX_PER_H, `RTCPT_IDX_CMP_L,
      `RTCPT_IDX_CMP_H, `RTCPT_IDX_PIT_CTRL, `RTCPT_IDX_PIT_IEN,
      `RTCPT_IDX_PIT_FLAG, `RTCPT_IDX_PIT_DBG, `RTCPT_IDX_EVT_EN:
        reg_hit = 1'b1;
      `RTCPT_IDX_PIT_STAT, `RTCPT_IDX_EVT_STAT:
        reg_hit = !wr;
      `RTCPT_IDX_EVT_CLR:
        reg_hit = wr;
      default:
        reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // counting clock source and its rising edge
  always_comb begin
    case (s_r.clock_source_sel)
      rtcpt_pkg::internal_fast_osc:  sel_w = internal_fast_osc;
      rtcpt_pkg::internal_slow_osc:  sel_w = internal_slow_osc;
      rtcpt_pkg::crystal_osc:        sel_w = crystal_osc;
      rtcpt_pkg::external_clock_pin: sel_w = external_clock_pin;
      default:                       sel_w = 1'b0;
    endcase
  end

  assign tick_w = sel_w && !s_r.src_q;

  ////////////////////////////////////////////////////////////////////////////
  // tick timer
  rtcpt_tick_timer #(
    .TICK_W (16)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif.timer)
  );

  assign tif.enable   = s_r.ctrl_act[`RTCPT_CTRL_EN_BIT];
  assign tif.interval = s_r.ctrl_act[4:1];
  assign tif.halt     = debug_halt && !s_r.run_dbg;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        access;
    logic        done;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [7:0]  wb;
    logic [15:0] cnt_inc;
    logic [2:0]  set;
    logic [2:0]  clr;
    logic [31:0] rdat;
    access  = 1'b0;
    done    = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    idx     = paddr[9:2];
    wb      = pwdata[7:0];
    cnt_inc = 16'h0000;
    set     = 3'h0;
    clr     = 3'h0;
    rdat    = 32'h0000_0000;
    s_nxt   = s_r;

    // selected source level, kept for edge detect
    s_nxt.src_q = sel_w;

    // counter, wrap and match
    if (tick_w) begin
      if (s_r.cnt_busy) begin
        if (s_r.cnt_wait <= 2'h1) begin
          s_nxt.cnt      = s_r.cnt_new;
          s_nxt.cnt_busy = 1'b0;
        end else begin
          s_nxt.cnt_wait = s_r.cnt_wait - 2'h1;
        end
      end else begin
        if (s_r.cnt == s_r.per) begin
          cnt_inc                 = 16'h0000;
          set[`RTCPT_EVT_WRAP]    = 1'b1;
        end else begin
          cnt_inc = s_r.cnt + 16'h0001;
        end
        s_nxt.cnt = cnt_inc;
        if (cnt_inc == s_r.cmp) begin
          set[`RTCPT_EVT_MATCH] = 1'b1;
        end
      end
      if (s_r.per_busy) begin
        if (s_r.per_wait <= 2'h1) begin
          s_nxt.per      = s_r.per_new;
          s_nxt.per_busy = 1'b0;
        end else begin
          s_nxt.per_wait = s_r.per_wait - 2'h1;
        end
      end
      if (s_r.ctrl_busy) begin
        if (s_r.ctrl_wait <= 2'h1) begin
          s_nxt.ctrl_act  = s_r.ctrl_sw;
          s_nxt.ctrl_busy = 1'b0;
        end else begin
          s_nxt.ctrl_wait = s_r.ctrl_wait - 2'h1;
        end
      end
    end
    set[`RTCPT_EVT_TICK] = tif.tick_event;

    // apb handshake, answer in the second access cycle
    access        = psel && penable;
    done          = access && s_r.pready;
    wr            = done && pwrite;
    rd            = done && !pwrite;
    s_nxt.pready  = access && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    if (access && !s_r.pready) begin
      s_nxt.pslverr = !reg_hit(idx, pwrite) || paddr[11:10] != 2'h0 ||
                      paddr[1:0] != 2'h0;
    end

    // read data
    case (idx)
      `RTCPT_IDX_STATUS: begin
        rdat[`RTCPT_STAT_CNT_BIT] = s_r.cnt_busy;
        rdat[`RTCPT_STAT_PER_BIT] = s_r.per_busy;
      end
      `RTCPT_IDX_INTFLAGS: rdat[1:0] = s_r.evt[1:0];
      `RTCPT_IDX_TEMP:     rdat[7:0] = s_r.temp;
      `RTCPT_IDX_CLOCK_SOURCE_SEL:   rdat[1:0] = s_r.clock_source_sel;
      `RTCPT_IDX_CNT_L:    rdat[7:0] = s_r.cnt[7:0];
      `RTCPT_IDX_CNT_H:    rdat[7:0] = s_r.temp;
      `RTCPT_IDX_PER_L:    rdat[7:0] = s_r.per[7:0];
      `RTCPT_IDX_PER_H:    rdat[7:0] = s_r.temp;
      `RTCPT_IDX_CMP_L:    rdat[7:0] = s_r.cmp[7:0];
      `RTCPT_IDX_CMP_H:    rdat[7:0] = s_r.temp;
      `RTCPT_IDX_PIT_CTRL: begin
        rdat[`RTCPT_CTRL_EN_BIT] = s_r.ctrl_sw[0];
        rdat[`RTCPT_CTRL_IV_MSB:`RTCPT_CTRL_IV_LSB] = s_r.ctrl_sw[4:1];
      end
      `RTCPT_IDX_PIT_STAT: rdat[0] = s_r.ctrl_busy;
      `RTCPT_IDX_PIT_IEN:  rdat[0] = s_r.pit_ien;
      `RTCPT_IDX_PIT_FLAG: rdat[0] = s_r.evt[`RTCPT_EVT_TICK];
      `RTCPT_IDX_PIT_DBG:  rdat[0] = s_r.run_dbg;
      `RTCPT_IDX_EVT_STAT: rdat[2:0] = s_r.evt;
      `RTCPT_IDX_EVT_EN:   rdat[2:0] = s_r.evt_en;
      default:             rdat = 32'h0000_0000;
    endcase
    if (access && !s_r.pready) begin
      s_nxt.prdata = rdat;
    end

    // low-byte reads stage the high byte
    if (rd) begin
      case (idx)
        `RTCPT_IDX_CNT_L: s_nxt.temp = s_r.cnt[15:8];
        `RTCPT_IDX_PER_L: s_nxt.temp = s_r.per[15:8];
        `RTCPT_IDX_CMP_L: s_nxt.temp = s_r.cmp[15:8];
        default:          s_nxt.temp = s_nxt.temp;
      endcase
    end

    // writes
    if (wr && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0) begin
      case (idx)
        `RTCPT_IDX_INTFLAGS: clr[1:0] = wb[1:0];
        `RTCPT_IDX_CLOCK_SOURCE_SEL:
          s_nxt.clock_source_sel = rtcpt_pkg::rtcpt_clk_src_t'(wb[1:0]);
        `RTCPT_IDX_TEMP,
        `RTCPT_IDX_CNT_L,
        `RTCPT_IDX_PER_L,
        `RTCPT_IDX_CMP_L: s_nxt.temp = wb;
        `RTCPT_IDX_CNT_H: begin
          s_nxt.cnt_new  = merge16(wb, s_r.temp);
          s_nxt.cnt_busy = 1'b1;
          s_nxt.cnt_wait = `RTCPT_SYNC_CYC;
        end
        `RTCPT_IDX_PER_H: begin
          s_nxt.per_new  = merge16(wb, s_r.temp);
          s_nxt.per_busy = 1'b1;
          s_nxt.per_wait = `RTCPT_SYNC_CYC;
        end
        `RTCPT_IDX_CMP_H: s_nxt.cmp = merge16(wb, s_r.temp);
        `RTCPT_IDX_PIT_CTRL: begin
          s_nxt.ctrl_sw   = {wb[`RTCPT_CTRL_IV_MSB:`RTCPT_CTRL_IV_LSB],
                             wb[`RTCPT_CTRL_EN_BIT]};
          s_nxt.ctrl_busy = 1'b1;
          s_nxt.ctrl_wait = `RTCPT_SYNC_CYC;
        end
        `RTCPT_IDX_PIT_IEN:  s_nxt.pit_ien = wb[0];
        `RTCPT_IDX_PIT_FLAG: clr[`RTCPT_EVT_TICK] = wb[0];
        `RTCPT_IDX_PIT_DBG:  s_nxt.run_dbg = wb[0];
        `RTCPT_IDX_EVT_CLR:  clr = wb[2:0];
        `RTCPT_IDX_EVT_EN:   s_nxt.evt_en = wb[2:0];
        default:             clr = 3'h0;
      endcase
    end

    // sticky events, set wins over clear
    s_nxt.evt      = (s_r.evt & ~clr) | set;
    s_nxt.irq      = |(s_nxt.evt & s_nxt.evt_en);
    s_nxt.tick_irq = s_nxt.evt[`RTCPT_EVT_TICK] && s_nxt.pit_ien;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.cnt      <= `RTCPT_RST_CNT;
      s_r.per      <= `RTCPT_RST_PER;
      s_r.per_new  <= `RTCPT_RST_PER;
      s_r.cmp      <= `RTCPT_RST_CMP;
      s_r.temp     <= `RTCPT_RST_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign irq      = s_r.irq;
  assign tick_irq = s_r.tick_irq;
  assign tif.rtc_tick = tick_w;

endmodule : rtcpt_counter

// File: rtcpt_regs.svh
`ifndef RTCPT_REGS_SVH
`define RTCPT_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define RTCPT_IDX_STATUS   8'h01
`define RTCPT_IDX_INTFLAGS 8'h03
`define RTCPT_IDX_TEMP     8'h04
`define RTCPT_IDX_CLOCK_SOURCE_SEL   8'h07
`define RTCPT_IDX_CNT_L    8'h08
`define RTCPT_IDX_CNT_H    8'h09
`define RTCPT_IDX_PER_L    8'h0a
`define RTCPT_IDX_PER_H    8'h0b
`define RTCPT_IDX_CMP_L    8'h0c
`define RTCPT_IDX_CMP_H    8'h0d
`define RTCPT_IDX_PIT_CTRL 8'h10
`define RTCPT_IDX_PIT_STAT 8'h11
`define RTCPT_IDX_PIT_IEN  8'h12
`define RTCPT_IDX_PIT_FLAG 8'h13
`define RTCPT_IDX_PIT_DBG  8'h15
`define RTCPT_IDX_EVT_STAT 8'h18
`define RTCPT_IDX_EVT_CLR  8'h19
`define RTCPT_IDX_EVT_EN   8'h1a

////////////////////////////////////////////////////////////////////////////
// reset values
`define RTCPT_RST_CNT      16'h0000
`define RTCPT_RST_PER      16'hffff
`define RTCPT_RST_CMP      16'h0000
`define RTCPT_RST_BYTE     8'h00

////////////////////////////////////////////////////////////////////////////
// field positions
`define RTCPT_CTRL_EN_BIT  0
`define RTCPT_CTRL_IV_LSB  3
`define RTCPT_CTRL_IV_MSB  6
`define RTCPT_STAT_CNT_BIT 1
`define RTCPT_STAT_PER_BIT 2
`define RTCPT_EVT_WRAP     0
`define RTCPT_EVT_MATCH    1
`define RTCPT_EVT_TICK     2

////////////////////////////////////////////////////////////////////////////
// timing, in counting-domain cycles
`define RTCPT_SYNC_CYC     2'h2
`define RTCPT_IV_OFF       4'h0
`define RTCPT_IV_RSVD      4'hf

`endif

// File: rtcpt_pkg.sv
package rtcpt_pkg;

  // counting clock source selection
  typedef enum logic [1:0] {
    internal_fast_osc,
    internal_slow_osc,
    crystal_osc,
    external_clock_pin
  } rtcpt_clk_src_t;

  // tick timer state
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick_event;
  } rtcpt_tmr_state_t;

  // main block state
  typedef struct packed {
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic           irq;
    logic           tick_irq;
    logic [7:0]     temp;
    rtcpt_clk_src_t clock_source_sel;
    logic           src_q;
    logic [15:0]    cnt;
    logic [15:0]    per;
    logic [15:0]    cmp;
    logic [15:0]    cnt_new;
    logic [15:0]    per_new;
    logic           cnt_busy;
    logic           per_busy;
    logic [1:0]     cnt_wait;
    logic [1:0]     per_wait;
    logic [4:0]     ctrl_sw;
    logic [4:0]     ctrl_act;
    logic           ctrl_busy;
    logic [1:0]     ctrl_wait;
    logic           pit_ien;
    logic           run_dbg;
    logic [2:0]     evt;
    logic [2:0]     evt_en;
  } rtcpt_state_t;

endpackage : rtcpt_pkg

// File: rtcpt_tick_if.sv
`timescale 1ns/1ps
interface rtcpt_tick_if;
  logic       rtc_tick;
  logic       enable;
  logic [3:0] interval;
  logic       halt;
  logic       tick_event;

  modport timer (
    input  rtc_tick,
    input  enable,
    input  interval,
    input  halt,
    output tick_event
  );

  modport owner (
    output rtc_tick,
    output enable,
    output interval,
    output halt,
    input  tick_event
  );
endinterface : rtcpt_tick_if

// File: rtcpt_tick_timer.sv
`timescale 1ns/1ps
`include "rtcpt_regs.svh"
module rtcpt_tick_timer #(
  parameter int TICK_W = 16
) (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst_n,
  // control and event
  rtcpt_tick_if.timer tif
);

  if (TICK_W != 16) begin : g_chk
    $error("rtcpt_tick_timer needs TICK_W of 16");
  end

  rtcpt_pkg::rtcpt_tmr_state_t s_r;
  rtcpt_pkg::rtcpt_tmr_state_t s_nxt;

  function automatic logic [15:0] last_count(input logic [3:0] iv);
    last_count = 16'((17'h1 << (iv + 4'h1)) - 17'h1);
  endfunction : last_count

  ////////////////////////////////////////////////////////////////////////////
  // interval counter
  always_comb begin
    s_nxt            = s_r;
    s_nxt.tick_event = 1'b0;
    if (!tif.enable || tif.interval == `RTCPT_IV_OFF ||
        tif.interval == `RTCPT_IV_RSVD) begin
      s_nxt.cnt = 16'h0000;
    end else if (tif.rtc_tick && !tif.halt) begin
      if (s_r.cnt >= last_count(tif.interval)) begin
        s_nxt.cnt        = 16'h0000;
        s_nxt.tick_event = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.tick_event = s_r.tick_event;

endmodule : rtcpt_tick_timer

// File: rtcpt_asserts.sv
`timescale 1ns/1ps
module rtcpt_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // debug and interrupts
  input wire logic        debug_halt,
  input wire logic        irq,
  input wire logic        tick_irq
);
  logic       ien_r;
  logic       dbg_r;
  logic [2:0] een_r;
  logic       wok;
  assign wok = psel && penable && pready && pwrite && !pslverr;
  // shadow of enables written over apb
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_r <= 1'b0;
      dbg_r <= 1'b0;
      een_r <= 3'h0;
    end else if (wok) begin
      if (paddr[9:2] == 8'h12) ien_r <= pwdata[0];
      if (paddr[9:2] == 8'h15) dbg_r <= pwdata[0];
      if (paddr[9:2] == 8'h1a) een_r <= pwdata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  chk_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer after access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without a request");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
  chk_misalign_err: assert property (
    (s_access and (paddr[1:0] != 2'h0)) |=> pslverr)
    else $error("misaligned access not refused");
  chk_ro_refused: assert property (
    (s_access and (pwrite && paddr[9:2] == 8'h11)) |=> pslverr)
    else $error("write to tick status not refused");
  chk_reset_quiet: assert property (
    $rose(rst_n) |-> !pready && !irq && !tick_irq)
    else $error("outputs active after reset");
  chk_tick_gate: assert property (tick_irq |-> ien_r || $past(ien_r))
    else $error("tick request while its enable is clear");
  chk_tick_halt: assert property (
    debug_halt && $past(debug_halt, 2) && !dbg_r && ien_r
    |-> !$rose(tick_irq))
    else $error("tick request while halted");
  chk_irq_gate: assert property (
    irq |-> een_r != 3'h0 || $past(een_r) != 3'h0)
    else $error("event request with all enables clear");
endmodule : rtcpt_asserts
bind rtcpt_counter rtcpt_asserts u_asserts (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq),
  .tick_irq(tick_irq)
);

// File: rtcpt_tb.sv
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  osc;
  logic        debug_halt;
  logic        irq;
  logic        tick_irq;
  int          n_errors;
  int          comparisons;
  logic [7:0]  rd_q;
  logic        err_q;
  logic [15:0] cnt_e;
  logic [15:0] rst_tab [12] = '{16'h0700, 16'h0800, 16'h0900, 16'h0aff,
    16'h0bff, 16'h0c00, 16'h0d00, 16'h1000, 16'h1100, 16'h1200, 16'h1300,
    16'h1500};
  logic [4:0]  off_tab [3] = '{5'h01, 5'h1f, 5'h02};

  rtcpt_counter DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fast_osc(osc[0]),
    .internal_slow_osc(osc[1]), .crystal_osc(osc[2]),
    .external_clock_pin(osc[3]), .debug_halt(debug_halt), .irq(irq),
    .tick_irq(tick_irq)
  );

  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    xfer(1'b1, {2'h0, x, 2'h0}, d);
    chk_bit("write error", 1'b0, err_q);
  endtask : wr

  task automatic rd(input logic [7:0] x, input logic [7:0] e);
    xfer(1'b0, {2'h0, x, 2'h0}, 8'h00);
    chk_byte($sformatf("reg %h", x), e, rd_q);
  endtask : rd

  task automatic wr16(input logic [7:0] x, input logic [15:0] d);
    wr(x, d[7:0]);
    wr(x + 8'h01, d[15:8]);
  endtask : wr16

  task automatic rd16(input logic [7:0] x, input logic [15:0] e);
    rd(x, e[7:0]);
    rd(x + 8'h01, e[15:8]);
  endtask : rd16

  // counting edges on one source
  task automatic edges(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      osc[k] <= 1'b1;
      repeat (2) @(posedge clk);
      osc[k] <= 1'b0;
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : edges

  task automatic tick_cfg(input logic [3:0] c, input logic en);
    wr(8'h10, 8'h00);
    edges(0, 2);
    wr(8'h10, {1'b0, c, 2'h0, en});
    rd(8'h11, 8'h01);
    edges(0, 2);
    rd(8'h11, 8'h00);
    wr(8'h13, 8'h01);
  endtask : tick_cfg
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    {rst_n, psel, penable, pwrite, debug_halt} = '0;
    {paddr, pwdata, osc} = '0;
    {n_errors, comparisons} = '0;
    cnt_e = 16'h0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk_bit("irq", 1'b0, irq);
    foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    xfer(1'b0, 12'h07c, 8'h00);
    chk_bit("unmapped", 1'b1, err_q);
    xfer(1'b1, 12'h031, 8'h00);
    chk_bit("misaligned", 1'b1, err_q);
    xfer(1'b1, 12'h044, 8'h01);
    chk_bit("read only", 1'b1, err_q);
    for (int k = 0; k < 4; k++) begin
      wr(8'h07, 8'(k));
      rd(8'h07, 8'(k));
      edges((k + 1) % 4, 3);
      edges(k, 2);
      cnt_e = cnt_e + 16'h0002;
      rd16(8'h08, cnt_e);
    end
    wr(8'h07, 8'h00);
    wr16(8'h08, 16'h00f0);
    rd(8'h01, 8'h02);
    edges(0, 1);
    rd(8'h01, 8'h02);
    edges(0, 1);
    rd(8'h01, 8'h00);
    rd16(8'h08, 16'h00f0);
    wr16(8'h0a, 16'h0003);
    rd(8'h01, 8'h04);
    rd(8'h04, 8'h03);
    edges(0, 2);
    rd(8'h01, 8'h00);
    rd16(8'h0a, 16'h0003);
    wr16(8'h0c, 16'h0002);
    rd16(8'h0c, 16'h0002);
    wr16(8'h08, 16'h0000);
    edges(0, 2);
    wr(8'h03, 8'h03);
    wr(8'h19, 8'h07);
    wr(8'h1a, 8'h03);
    edges(0, 2);
    rd(8'h03, 8'h02);
    edges(0, 1);
    rd16(8'h08, 16'h0003);
    rd(8'h03, 8'h02);
    edges(0, 1);
    rd16(8'h08, 16'h0000);
    rd(8'h03, 8'h03);
    rd(8'h18, 8'h03);
    chk_bit("irq", 1'b1, irq);
    wr(8'h03, 8'h01);
    rd(8'h03, 8'h02);
    wr(8'h19, 8'h03);
    rd(8'h18, 8'h00);
    chk_bit("irq", 1'b0, irq);
    wr(8'h1a, 8'h00);
    wr(8'h12, 8'h01);
    for (int c = 1; c < 13; c++) begin
      tick_cfg(4'(c), 1'b1);
      edges(0, (2 << c) - 1);
      rd(8'h13, 8'h00);
      edges(0, 1);
      rd(8'h13, 8'h01);
      chk_bit("tick irq", 1'b1, tick_irq);
    end
    tick_cfg(4'h1, 1'b1);
    edges(0, 4);
    wr(8'h13, 8'h00);
    rd(8'h13, 8'h01);
    wr(8'h13, 8'h01);
    rd(8'h13, 8'h00);
    wr(8'h12, 8'h00);
    edges(0, 4);
    rd(8'h13, 8'h01);
    chk_bit("tick irq", 1'b0, tick_irq);
    foreach (off_tab[i]) begin
      tick_cfg(off_tab[i][4:1], off_tab[i][0]);
      edges(0, 40);
      rd(8'h13, 8'h00);
    end
    wr(8'h12, 8'h01);
    tick_cfg(4'h1, 1'b1);
    debug_halt <= 1'b1;
    edges(0, 8);
    rd(8'h13, 8'h00);
    debug_halt <= 1'b0;
    edges(0, 4);
    rd(8'h13, 8'h01);
    wr(8'h13, 8'h01);
    wr(8'h15, 8'h01);
    debug_halt <= 1'b1;
    edges(0, 4);
    rd(8'h13, 8'h01);
    debug_halt <= 1'b0;
    report_and_stop();
  end
endmodule : testbench
